// ### verilog/plg_consts.svh
/*
  Constants of the protection lock guard: register offsets, field
  positions, reset values, link command codes and timing counts.
  Assumes a 40 MHz system clock and a byte-wide register window.

*/
`ifndef PLG_CONSTS_SVH
`define PLG_CONSTS_SVH

`define PLG_OFF_STATUS 8'h00
`define PLG_OFF_VCFG1 8'h04
`define PLG_OFF_CFG 8'h08
`define PLG_OFF_KEY_LO 8'h0c
`define PLG_OFF_KEY_HI 8'h10
`define PLG_OFF_IRQ_STAT 8'h14
`define PLG_OFF_IRQ_CLR 8'h18
`define PLG_OFF_IRQ_EN 8'h1c
`define PLG_OFF_OTP 8'h20
`define PLG_OFF_CTRL 8'h24

`define PLG_VCFG_FRZ 0
`define PLG_CTRL_ERRCLR 0
`define PLG_CFG_PER 1
`define PLG_CFG_PW 2
`define PLG_CFG_RDP 5
`define PLG_CFG_RST 8'hff
`define PLG_OTP_RST 8'hff
`define PLG_KEY_RST 64'hffffffffffffffff
`define PLG_KEY_BYTES 4'h8

`define PLG_CMD_NONE 8'h00
`define PLG_CMD_LOCK_CLR 8'ha6
`define PLG_CMD_UNLOCK 8'he9
`define PLG_CMD_KEY_PROG 8'he8
`define PLG_CMD_CFG_PROG 8'h2f
`define PLG_CMD_PB_PROG 8'hfd
`define PLG_CMD_PB_ERASE 8'he4
`define PLG_CMD_VSB_WR 8'hfb
`define PLG_CMD_OTP_PROG 8'h42
`define PLG_CMD_SRST 8'hf0

`define PLG_CLK_HZ 40000000
`define PLG_RATE_US 100
`define PLG_RATE_CYC (`PLG_RATE_US * (`PLG_CLK_HZ / 1000000))

`endif

// ### verilog/plg_pkg.sv
/*
  Types shared by the protection lock guard modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package plg_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_OPC = 2'b01,
    ST_DATA = 2'b10
  } plg_st_e;
  typedef logic [7:0] plg_byte_t;
endpackage

// ### verilog/plg_sync.sv
/*
  Two-stage synchroniser for a group of unrelated pin levels.
  Assumes every input bit is a slow level seen on its own.
*/
`timescale 1ns/1ps
module plg_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset
  input wire logic [W-1:0] d_i, // asynchronous pin levels
  output logic [W-1:0] q_o // synchronised levels
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule

// ### verilog/plg_rx.sv
/*
  Serial command receiver: finds link clock edges, shifts bytes in
  most significant bit first and marks frame start and end.
  Assumes synchronised inputs and a link clock far slower than clk_i.
*/
`timescale 1ns/1ps
module plg_rx (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset
  input wire logic sck_i, // link clock level
  input wire logic cs_n_i, // frame select, active low
  input wire logic si_i, // serial data in
  output logic start_o, // frame begins, pulse
  output logic byte_vld_o, // byte complete, pulse
  output plg_pkg::plg_byte_t byte_o, // received byte
  output logic end_o // frame ends, pulse
);
  import plg_pkg::*;
  logic sck_q, cs_q;
  logic [6:0] sh_q;
  logic [2:0] bit_q;
  wire rise_w = sck_i & ~sck_q & ~cs_n_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_q <= 1'b0;
      cs_q <= 1'b1;
      sh_q <= 7'h00;
      bit_q <= 3'h0;
      start_o <= 1'b0;
      end_o <= 1'b0;
      byte_vld_o <= 1'b0;
      byte_o <= 8'h00;
    end else begin
      sck_q <= sck_i;
      cs_q <= cs_n_i;
      start_o <= cs_q & ~cs_n_i;
      end_o <= ~cs_q & cs_n_i;
      byte_vld_o <= rise_w & (bit_q == 3'h7);
      if (cs_n_i) begin
        bit_q <= 3'h0;
      end else if (rise_w) begin
        sh_q <= {sh_q[5:0], si_i};
        bit_q <= bit_q + 3'h1;
        if (bit_q == 3'h7) begin
          byte_o <= {sh_q, si_i};
        end
      end
    end
  end
endmodule

// ### verilog/plg_top.sv
/*
  Protection lock guard: lock flag, password unlock with rate limit,
  persistent and volatile sector bits, scheme selection, one-time
  region freeze and read redirection, with a Wishbone register port.
  Assumes a serial host on the link pins and a classic Wishbone master.
*/
// Chosen here: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "plg_consts.svh"
module plg_top #(
  parameter int NSECT = 128,
  parameter int AW = 23,
  parameter logic [AW-1:0] BOOT_ADDR = '0,
  parameter int RATE_CYC = `PLG_RATE_CYC
) (
  input wire logic clk_i, // 40 MHz system clock
  input wire logic rst_i, // power-on reset, synchronous
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_we_i, // write enable
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic link_sck_i, // link clock pin
  input wire logic link_cs_n_i, // link select pin
  input wire logic link_si_i, // link data pin
  input wire logic hw_rst_n_i, // hardware reset pin
  input wire logic [AW-1:0] rd_addr_i, // requested read address
  output logic [AW-1:0] rd_addr_o, // address used for array and ECC
  output logic [NSECT-1:0] sector_prot_o, // sector write-protected
  output logic busy_o, // unlock check or rate wait in progress
  output logic irq_o // interrupt, level
);
  import plg_pkg::*;
  localparam int SW = $clog2(NSECT);
  localparam int TW = $clog2(RATE_CYC + 1);

  logic [3:0] pin_s;
  logic fr_start, fr_end, b_vld;
  plg_byte_t b_dat;

  // Pins rest at their idle levels, so reset shows no false link edge.
  plg_sync #(.W(4), .RST_VAL(4'hc)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({hw_rst_n_i, link_cs_n_i, link_sck_i, link_si_i}),
    .q_o(pin_s)
  );

  plg_rx u_rx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sck_i(pin_s[1]),
    .cs_n_i(pin_s[2]),
    .si_i(pin_s[0]),
    .start_o(fr_start),
    .byte_vld_o(b_vld),
    .byte_o(b_dat),
    .end_o(fr_end)
  );

  plg_st_e st_q, st_d;
  plg_byte_t cmd_q, cfg_q, otp_q;
  logic [3:0] cnt_q, stat_q, en_q;
  logic [63:0] kbuf_q, key_q;
  logic [NSECT-1:0] pb_q, vsb_q;
  logic [TW-1:0] tmr_q;
  logic lock_q, busy_q, perr_q, freeze_q, failw_q;
  logic [31:0] rdat_w;

  // Hardware reset pin, already synchronised.
  wire hw_rst = ~pin_s[3];
  // Password scheme wins if both scheme bits were programmed.
  wire pw_mode = ~cfg_q[`PLG_CFG_PW];
  wire per_mode = ~cfg_q[`PLG_CFG_PER] & ~pw_mode;
  wire opc_w = b_vld && (st_q == ST_OPC);
  wire dat_w = b_vld && (st_q == ST_DATA);
  wire first_w = dat_w && (cnt_q == 4'h0);
  wire end_w = fr_end && (st_q == ST_DATA);
  wire is_srst = opc_w && (b_dat == `PLG_CMD_SRST);
  wire refuse_w = opc_w && busy_q && !is_srst;
  wire take_w = opc_w && !busy_q;
  wire is_lclr = take_w && (b_dat == `PLG_CMD_LOCK_CLR);
  wire unl_op = take_w && (b_dat == `PLG_CMD_UNLOCK);
  wire is_unl = unl_op && pw_mode;
  wire is_erase = take_w && (b_dat == `PLG_CMD_PB_ERASE);
  wire pb_prog = first_w && (cmd_q == `PLG_CMD_PB_PROG);
  wire vsb_wr = first_w && (cmd_q == `PLG_CMD_VSB_WR);
  wire otp_wr = first_w && (cmd_q == `PLG_CMD_OTP_PROG) && !freeze_q;
  wire cfg_wr = first_w && (cmd_q == `PLG_CMD_CFG_PROG);
  wire key_wr = end_w && (cmd_q == `PLG_CMD_KEY_PROG)
    && (cnt_q == `PLG_KEY_BYTES) && !pw_mode;
  wire eval_w = end_w && (cmd_q == `PLG_CMD_UNLOCK) && pw_mode;
  // All 64 bits must have arrived; a short or long frame fails.
  wire match_w = (cnt_q == `PLG_KEY_BYTES) && (kbuf_q == key_q);
  wire good_w = eval_w && match_w;
  wire bad_w = eval_w && !match_w;
  wire pb_try = pb_prog || is_erase;
  wire pb_ok = pb_try && lock_q;
  wire pb_fail = pb_try && !lock_q;
  wire release_w = failw_q && (tmr_q == '0) && !perr_q;
  wire [NSECT-1:0] one_w = {{(NSECT - 1){1'b0}}, 1'b1};
  wire [NSECT-1:0] hot_w = one_w << b_dat[SW-1:0];
  wire rd_prot_w = pw_mode && !cfg_q[`PLG_CFG_RDP] && !lock_q;

  // Command frame sequencing.
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: if (fr_start) st_d = ST_OPC;
      ST_OPC: if (b_vld) st_d = ST_DATA;
      ST_DATA: st_d = ST_DATA;
      default: st_d = ST_IDLE;
    endcase
    if (fr_end) st_d = ST_IDLE;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || hw_rst) begin
      st_q <= ST_IDLE;
      cmd_q <= `PLG_CMD_NONE;
      cnt_q <= 4'h0;
      kbuf_q <= 64'h0;
    end else begin
      st_q <= st_d;
      if (opc_w) begin
        cmd_q <= refuse_w ? `PLG_CMD_NONE : b_dat;
        cnt_q <= 4'h0;
      end else if (dat_w) begin
        cnt_q <= cnt_q + {3'h0, cnt_q != 4'hf};
        kbuf_q <= {kbuf_q[55:0], b_dat};
      end
    end
  end

  // Lock flag: power-on reset sets it; hardware reset follows the scheme.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_q <= 1'b1;
    end else if (hw_rst) begin
      lock_q <= !pw_mode;
    end else if (is_lclr) begin
      lock_q <= 1'b0;
    end else if (good_w) begin
      lock_q <= 1'b1;
    end
  end
  // A software reset has no branch above, so the flag holds.

  // Busy and error: a wrong key keeps busy for the full interval.
  // Soft reset cannot release busy, so it gives no faster retries.
  always_ff @(posedge clk_i) begin
    if (rst_i || hw_rst) begin
      busy_q <= 1'b0;
      failw_q <= 1'b0;
      tmr_q <= '0;
    end else begin
      if (is_unl) begin
        busy_q <= 1'b1;
      end else if (good_w) begin
        busy_q <= 1'b0;
      end else if (release_w) begin
        busy_q <= 1'b0;
      end
      if (bad_w) begin
        failw_q <= 1'b1;
        tmr_q <= TW'(RATE_CYC);
      end else begin
        if (release_w) failw_q <= 1'b0;
        if (tmr_q != '0) tmr_q <= tmr_q - TW'(1);
      end
    end
  end

  wire errclr_w;
  always_ff @(posedge clk_i) begin
    if (rst_i || hw_rst) begin
      perr_q <= 1'b0;
    end else if (bad_w || pb_fail) begin
      perr_q <= 1'b1;
    end else if (errclr_w || is_srst) begin
      perr_q <= 1'b0;
    end
  end

  // Non-volatile cells: only the power-on reset restores erased values.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pb_q <= '1;
      cfg_q <= `PLG_CFG_RST;
      otp_q <= `PLG_OTP_RST;
    end else begin
      if (is_erase && pb_ok) begin
        pb_q <= '1;
      end else if (pb_prog && pb_ok) begin
        pb_q <= pb_q & ~hot_w;
      end
      cfg_q <= cfg_wr ? (cfg_q & b_dat) : cfg_q;
      otp_q <= otp_wr ? (otp_q & b_dat) : otp_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || hw_rst) begin
      vsb_q <= '1;
    end else if (vsb_wr) begin
      vsb_q <= b_dat[7] ? (vsb_q | hot_w) : (vsb_q & ~hot_w);
    end
  end

  // Wishbone slave: one wait state, ack for one cycle per request.
  wire wb_req = wb_cyc_i & wb_stb_i;
  wire wb_wr = wb_req & wb_we_i & wb_ack_o;
  wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] wbits = wb_dat_i & wmask;
  wire wr_vcfg = wb_wr && (wb_adr_i == `PLG_OFF_VCFG1);
  wire wr_klo = wb_wr && (wb_adr_i == `PLG_OFF_KEY_LO) && !pw_mode;
  wire wr_khi = wb_wr && (wb_adr_i == `PLG_OFF_KEY_HI) && !pw_mode;
  wire wr_clr = wb_wr && (wb_adr_i == `PLG_OFF_IRQ_CLR);
  wire wr_en = wb_wr && (wb_adr_i == `PLG_OFF_IRQ_EN);
  assign errclr_w = wb_wr && (wb_adr_i == `PLG_OFF_CTRL)
    && wbits[`PLG_CTRL_ERRCLR];
  wire [31:0] key_lo_w = pw_mode ? 32'h0 : key_q[31:0];
  wire [31:0] key_hi_w = pw_mode ? 32'h0 : key_q[63:32];

  always_comb begin
    unique case (wb_adr_i)
      `PLG_OFF_STATUS: rdat_w = {26'h0, per_mode, pw_mode, freeze_q,
        lock_q, perr_q, busy_q};
      `PLG_OFF_VCFG1: rdat_w = {31'h0, freeze_q};
      `PLG_OFF_CFG: rdat_w = {24'h0, cfg_q};
      `PLG_OFF_KEY_LO: rdat_w = key_lo_w;
      `PLG_OFF_KEY_HI: rdat_w = key_hi_w;
      `PLG_OFF_IRQ_STAT: rdat_w = {28'h0, stat_q};
      `PLG_OFF_IRQ_EN: rdat_w = {28'h0, en_q};
      `PLG_OFF_OTP: rdat_w = {24'h0, otp_q};
      default: rdat_w = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      if (wb_req & ~wb_ack_o) wb_dat_o <= rdat_w;
    end
  end

  // The key can only lose ones; a one over a zero is silently ignored.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key_q <= `PLG_KEY_RST;
      freeze_q <= 1'b0;
    end else begin
      if (key_wr) begin
        key_q <= key_q & kbuf_q;
      end else begin
        if (wr_klo) key_q[31:0] <= key_q[31:0] & (wb_dat_i | ~wmask);
        if (wr_khi) key_q[63:32] <= key_q[63:32] & (wb_dat_i | ~wmask);
      end
      if (wr_vcfg && wbits[`PLG_VCFG_FRZ]) freeze_q <= 1'b1;
    end
  end

  // Events: unlock pass, unlock fail, command refused, busy ended.
  wire busy_fall = busy_q && (good_w || release_w || hw_rst);
  wire [3:0] ev_w = {busy_fall, refuse_w || pb_fail || unl_op && !pw_mode,
    bad_w, good_w};
  wire [3:0] stat_d = (stat_q & ~(wr_clr ? wbits[3:0] : 4'h0)) | ev_w;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= 4'h0;
      en_q <= 4'h0;
      irq_o <= 1'b0;
      busy_o <= 1'b0;
      rd_addr_o <= '0;
      sector_prot_o <= '0;
    end else begin
      stat_q <= stat_d;
      if (wr_en) en_q <= (en_q & ~wmask[3:0]) | wbits[3:0];
      irq_o <= |(stat_q & en_q);
      busy_o <= busy_q;
      rd_addr_o <= rd_prot_w ? BOOT_ADDR : rd_addr_i;
      sector_prot_o <= ~pb_q | ~vsb_q;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_good_key;
    good_w && !hw_rst;
  endsequence
  sequence s_bad_key;
    bad_w && !hw_rst;
  endsequence

  AST_HWR_LOCK: assert property (hw_rst |=> lock_q == !pw_mode)
    else $error("lock flag wrong after hardware reset");
  AST_SRST_KEEP: assert property ((is_srst && !hw_rst)
    |=> $stable(lock_q))
    else $error("software reset changed the lock flag");
  AST_LCLR: assert property ((is_lclr && !hw_rst) |=> !lock_q)
    else $error("lock clear did not drop the flag");
  AST_PER_STAYS: assert property ((!pw_mode && !lock_q && !hw_rst)
    |=> !lock_q)
    else $error("lock flag rose in persistent scheme");
  AST_UNL_OK: assert property (s_good_key
    |=> lock_q && !busy_q)
    else $error("good key did not unlock at once");
  AST_UNL_BAD: assert property (s_bad_key
    |=> perr_q && busy_q && !lock_q)
    else $error("bad key not reported");
  AST_UNL_BUSY: assert property ((is_unl && !hw_rst) |=> busy_q)
    else $error("accepted unlock did not raise busy");
  AST_PER_NO_EVAL: assert property (!pw_mode |-> !(good_w || bad_w))
    else $error("unlock judged outside the password scheme");
  AST_RATE_HOLD: assert property (s_bad_key |=> busy_q [*8])
    else $error("busy released early after bad key");
  AST_RATE_TMR: assert property (s_bad_key
    |=> tmr_q == TW'(RATE_CYC))
    else $error("rate timer not loaded");
  AST_TMR_BUSY: assert property ((tmr_q != '0 && !hw_rst) |=> busy_q)
    else $error("busy dropped while rate timer runs");
  AST_KEY_ZERO: assert property (##1
    ((key_q & ~$past(key_q)) == 64'h0))
    else $error("key bit went from zero to one");
  AST_KEY_SEALED: assert property (pw_mode |=> $stable(key_q))
    else $error("sealed key changed");
  AST_CFG_OTP: assert property (##1
    ((cfg_q & ~$past(cfg_q)) == 8'h0))
    else $error("scheme bit reverted");
  AST_PB_HELD: assert property (!lock_q |=> $stable(pb_q))
    else $error("sector bits changed while locked");
  AST_PB_PROT: assert property ((pb_q != '1)
    |=> ((sector_prot_o | $past(pb_q)) == '1))
    else $error("cleared persistent bit left sector open");
  AST_PB_FAIL: assert property ((pb_fail && !hw_rst) |=> perr_q)
    else $error("locked sector bit command did not fail");
  AST_REDIR: assert property (rd_prot_w |=> rd_addr_o == BOOT_ADDR)
    else $error("read not redirected to boot sector");
  AST_FRZ: assert property (freeze_q |=> $stable(otp_q))
    else $error("one-time region changed while frozen");
endmodule

// ### test/plg_host.sv
/*
  Serial host model that drives the lock guard link pins, mode 0 with
  the most significant bit first. Each frame ends with a fixed gap;
  the caller polls busy after every frame except an unlock.
*/
`timescale 1ns/1ps
module plg_host (
  output logic sck_o, // link clock, still between frames
  output logic cs_n_o, // frame select, active low
  output logic si_o // serial data
);
  logic last_q;
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    last_q = 1'b0;
  end
  // Bytes go out whole; nb data bytes come from the top of dat.
  task automatic send(input logic [7:0] op, input logic [63:0] dat,
                      input int nb);
    logic [71:0] sh;
    sh = {op, dat};
    cs_n_o = 1'b0;
    for (int i = 0; i < 8 * (nb + 1); i++) begin
      si_o = sh[71 - i];
      last_q = sh[71 - i];
      #100 sck_o = 1'b1;
      #100 sck_o = 1'b0;
    end
    #100 cs_n_o = 1'b1;
    // A released data line must not look like it still holds data.
    si_o = ~last_q;
    #500;
  endtask
endmodule

// ### test/protect_lock_password_guard_tb.sv
/*
  Self-checking bench for the protection lock guard top module.
  Assumes the serial host model and the design files are compiled first.
*/
`timescale 1ns/1ps
`include "plg_consts.svh"
module protect_lock_password_guard_tb;
  localparam int RC = 200;
  localparam logic [22:0] BOOT = 23'h004000;
  localparam logic [63:0] K = 64'h5a5a0f0f3c3c9696;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic link_sck_i;
  logic link_cs_n_i;
  logic link_si_i;
  logic hw_rst_n_i = 1'b1;
  logic [22:0] rd_addr_i = 23'h0;
  logic [22:0] rd_addr_o;
  logic [127:0] sector_prot_o;
  logic busy_o;
  logic irq_o;
  int bad_count = 0;
  int cmp_count = 0;

  always #12.5 clk_i = ~clk_i;

  plg_top #(.RATE_CYC(RC), .BOOT_ADDR(BOOT)) plg_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .link_sck_i(link_sck_i),
    .link_cs_n_i(link_cs_n_i), .link_si_i(link_si_i),
    .hw_rst_n_i(hw_rst_n_i), .rd_addr_i(rd_addr_i),
    .rd_addr_o(rd_addr_o), .sector_prot_o(sector_prot_o),
    .busy_o(busy_o), .irq_o(irq_o));
  plg_host plg_host_inst (.sck_o(link_sck_i), .cs_n_o(link_cs_n_i),
    .si_o(link_si_i));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [31:0] d, input logic [3:0] sel,
                    output logic [31:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    wb_sel_i <= sel;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      stop_test();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] adr, output logic [31:0] q);
    wb(1'b0, adr, 32'h0, 4'hf, q);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, adr, d, 4'hf, q);
  endtask

  task automatic sbit(input int b, input logic e, input string nm);
    logic [31:0] q;
    rd(`PLG_OFF_STATUS, q);
    chk(nm, {31'h0, e}, {31'h0, q[b]});
  endtask

  // The host waits for busy to clear before its next attempt.
  task automatic idle(input int lim);
    int n;
    n = 0;
    while (busy_o !== 1'b0) begin
      @(posedge clk_i);
      n++;
      if (n > lim) begin
        bad_count++;
        stop_test();
      end
    end
  endtask

  task automatic cmd(input logic [7:0] op, input logic [63:0] d,
                     input int nb);
    plg_host_inst.send(op, d, nb);
    @(posedge clk_i);
    if (op != `PLG_CMD_UNLOCK) begin
      idle(RC * 2);
    end
  endtask

  task automatic hwr();
    @(posedge clk_i);
    hw_rst_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    hw_rst_n_i <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask

  task automatic t_reset();
    logic [31:0] q;
    sbit(2, 1'b1, "lock");
    sbit(0, 1'b0, "busy");
    rd(`PLG_OFF_KEY_LO, q);
    chk("key_lo", 32'hffffffff, q);
    rd(`PLG_OFF_CFG, q);
    chk("cfg", 32'hff, q);
    rd(8'h3c, q);
    chk("unmapped", 32'h0, q);
  endtask

  task automatic t_key();
    logic [31:0] q;
    cmd(`PLG_CMD_KEY_PROG, K, 8);
    cmd(`PLG_CMD_KEY_PROG, 64'hffffffffffffffff, 8);
    rd(`PLG_OFF_KEY_HI, q);
    chk("key_hi", K[63:32], q);
    rd(`PLG_OFF_KEY_LO, q);
    chk("key_lo", K[31:0], q);
    sbit(1, 1'b0, "p_err");
  endtask

  task automatic t_sect();
    cmd(`PLG_CMD_PB_PROG, {8'h05, 56'h0}, 1);
    cmd(`PLG_CMD_VSB_WR, {8'h85, 56'h0}, 1);
    cmd(`PLG_CMD_VSB_WR, {8'h06, 56'h0}, 1);
    chk("prot_a", 32'h3, {30'h0, sector_prot_o[6:5]});
    cmd(`PLG_CMD_VSB_WR, {8'h86, 56'h0}, 1);
    chk("prot_b", 32'h1, {30'h0, sector_prot_o[6:5]});
    cmd(`PLG_CMD_LOCK_CLR, 64'h0, 0);
    sbit(2, 1'b0, "lock_clr");
    cmd(`PLG_CMD_PB_PROG, {8'h07, 56'h0}, 1);
    sbit(1, 1'b1, "p_err_pb");
    chk("prot_c", 32'h0, {31'h0, sector_prot_o[7]});
    wr(`PLG_OFF_CTRL, 32'h1);
    cmd(`PLG_CMD_PB_ERASE, 64'h0, 0);
    chk("prot_d", 32'h1, {31'h0, sector_prot_o[5]});
    wr(`PLG_OFF_CTRL, 32'h1);
    cmd(`PLG_CMD_SRST, 64'h0, 0);
    sbit(2, 1'b0, "lock_srst");
    hwr();
    sbit(2, 1'b1, "lock_hwr");
    cmd(`PLG_CMD_PB_ERASE, 64'h0, 0);
    chk("prot_e", 32'h0, {29'h0, sector_prot_o[7:5]});
  endtask

  task automatic t_otp();
    logic [31:0] q;
    cmd(`PLG_CMD_OTP_PROG, {8'h3c, 56'h0}, 1);
    rd(`PLG_OFF_OTP, q);
    chk("otp", 32'h3c, q);
    wr(`PLG_OFF_VCFG1, 32'h1);
    cmd(`PLG_CMD_OTP_PROG, 64'h0, 1);
    rd(`PLG_OFF_OTP, q);
    chk("otp_frozen", 32'h3c, q);
    sbit(3, 1'b1, "freeze");
  endtask

  task automatic t_irq();
    logic [31:0] q;
    wr(`PLG_OFF_IRQ_CLR, 32'hf);
    wr(`PLG_OFF_IRQ_EN, 32'hf);
    wb(1'b1, `PLG_OFF_IRQ_EN, 32'h0, 4'h0, q);
    rd(`PLG_OFF_IRQ_EN, q);
    chk("irq_en_sel", 32'hf, q);
    wr(`PLG_OFF_IRQ_EN, 32'h0);
    cmd(`PLG_CMD_UNLOCK, K, 8);
    wr(`PLG_OFF_CTRL, 32'h1);
    idle(RC * 2);
    rd(`PLG_OFF_IRQ_STAT, q);
    chk("irq_refused", 32'h4, q & 32'h4);
    chk("irq_masked", 32'h0, {31'h0, irq_o});
    wr(`PLG_OFF_IRQ_EN, 32'h4);
    repeat (2) @(posedge clk_i);
    chk("irq_on", 32'h1, {31'h0, irq_o});
    wr(`PLG_OFF_IRQ_CLR, 32'h4);
    repeat (2) @(posedge clk_i);
    chk("irq_off", 32'h0, {31'h0, irq_o});
  endtask

  task automatic t_pw();
    logic [31:0] q;
    int n;
    cmd(`PLG_CMD_CFG_PROG, {8'hfb, 56'h0}, 1);
    rd(`PLG_OFF_CFG, q);
    chk("cfg_pw", 32'hfb, q);
    sbit(4, 1'b1, "pw_mode");
    rd(`PLG_OFF_KEY_LO, q);
    chk("key_sealed", 32'h0, q);
    wr(`PLG_OFF_KEY_LO, 32'h0);
    cmd(`PLG_CMD_KEY_PROG, 64'h0, 8);
    cmd(`PLG_CMD_CFG_PROG, {8'hff, 56'h0}, 1);
    rd(`PLG_OFF_CFG, q);
    chk("cfg_keep", 32'hfb, q);
    hwr();
    sbit(2, 1'b0, "lock_pw");
    wr(`PLG_OFF_IRQ_CLR, 32'hf);
    wr(`PLG_OFF_IRQ_EN, 32'h2);
    cmd(`PLG_CMD_UNLOCK, K ^ 64'h1, 8);
    rd(`PLG_OFF_STATUS, q);
    chk("fail_st", 32'h3, q & 32'h7);
    chk("irq_fail", 32'h1, {31'h0, irq_o});
    cmd(`PLG_CMD_UNLOCK, K, 8);
    sbit(2, 1'b0, "lock_busy");
    wr(`PLG_OFF_CTRL, 32'h1);
    idle(RC * 2);
    cmd(`PLG_CMD_UNLOCK, K ^ 64'h1, 8);
    wr(`PLG_OFF_CTRL, 32'h1);
    n = 0;
    while (busy_o !== 1'b0 && n < RC * 2) begin
      @(posedge clk_i);
      n++;
    end
    // About twenty cycles of the interval pass before counting starts.
    chk("rate", 32'h1,
        {31'h0, (n >= RC * 4 / 5 - 30) && (n <= RC * 6 / 5)});
    cmd(`PLG_CMD_UNLOCK, K, 7);
    rd(`PLG_OFF_STATUS, q);
    chk("short_st", 32'h3, q & 32'h7);
    wr(`PLG_OFF_CTRL, 32'h1);
    idle(RC * 2);
    cmd(`PLG_CMD_UNLOCK, K, 8);
    chk("good_busy", 32'h0, {31'h0, busy_o});
    sbit(2, 1'b1, "lock_good");
  endtask

  task automatic t_rdp();
    @(posedge clk_i);
    rd_addr_i <= 23'h012345;
    repeat (3) @(posedge clk_i);
    chk("rd_addr", 32'h012345, {9'h0, rd_addr_o});
    cmd(`PLG_CMD_CFG_PROG, {8'hdf, 56'h0}, 1);
    // Read protection only bites while the lock flag is down.
    hwr();
    repeat (3) @(posedge clk_i);
    chk("rd_boot", {9'h0, BOOT}, {9'h0, rd_addr_o});
    cmd(`PLG_CMD_UNLOCK, K, 8);
    chk("rd_open", 32'h012345, {9'h0, rd_addr_o});
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    t_reset();
    t_key();
    t_sect();
    t_otp();
    t_irq();
    t_pw();
    t_rdp();
    stop_test();
  end
endmodule
